// ---- adc_startup_timer_clock_select_tb_top.sv ----
`timescale 1ns/1ps
module adc_startup_timer_clock_select_tb_top;
  import adcst_pkg::*;
  // ==========================================
  // Signals
  logic        mclk_i, rst_i, wr, rd, fsd, scan_mode, scan_done;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic        conv, rdy, restart, ce, irq, gate, osc, ext, pin, pin_oe, pin_q;
  int          mismatches, n_tests, cycles, t0, n, k;
  int          irq_cnt, rst_cnt, tgl_cnt, ce_cnt;

  adcst_host host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
                   .rd_o(rd), .rdata_i(rdata));
  adcst_seq DUT (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .full_shutdown_cmd_i(fsd),
    .scan_mode_i(scan_mode), .scan_cycle_done_i(scan_done), .converting_o(conv),
    .adc_ready_o(rdy), .conv_restart_o(restart), .modulator_ce_o(ce), .irq_o(irq),
    .mclk_gate_en_o(gate), .osc_en_o(osc), .ext_clk_sel_o(ext), .clk_pin_o(pin),
    .clk_pin_oe_o(pin_oe));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // ==========================================
  // Event counters and timeout
  always @(posedge mclk_i) begin
    cycles++;
    if (irq === 1'b1) irq_cnt++;
    if (restart === 1'b1) rst_cnt++;
    if (ce === 1'b1) ce_cnt++;
    if (pin !== pin_q) tgl_cnt++;
    pin_q = pin;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Bounded wait on the conversion flag
  task automatic wait_conv(input logic lvl, input int lim);
    k = 0;
    while (conv !== lvl && k < lim) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
  endtask : wait_conv

  task automatic scan_pulse();
    @(posedge mclk_i);
    scan_done <= 1'b1;
    t0 = cycles;
    @(posedge mclk_i);
    scan_done <= 1'b0;
  endtask : scan_pulse

  // ==========================================
  // Main sequence
  initial begin
    {mismatches, n_tests, cycles, irq_cnt, rst_cnt, tgl_cnt, ce_cnt} = '0;
    {fsd, scan_mode, scan_done, pin_q} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    host.rd_reg(ADDR_STAT, v);
    chk(v[8:0], SETTLE_FULL);
    chk({v[13], v[9], osc, ext, pin_oe}, 5'h02);
    host.wr_reg(8'h10, 32'hffffffff);
    host.rd_reg(8'h10, v);
    chk(v, 32'h00000000);
    // Shutdown to conversion through the bus, with a same-value rewrite
    host.wr_reg(ADDR_SCAN, 32'h00000404);
    host.wr_reg(ADDR_CFG0, {30'h0, PWR_CONV});
    t0 = cycles;
    repeat (400) @(posedge mclk_i);
    host.rd_reg(ADDR_STAT, v);
    n = v[8:0];
    chk(conv, 1'b0);
    host.wr_reg(ADDR_CFG0, {30'h0, PWR_CONV});
    host.rd_reg(ADDR_STAT, v);
    chk(v[8:0] <= n && n < 256, 1'b1);
    wait_conv(1'b1, 2000);
    n = cycles - t0;
    chk(n >= 1024, 1'b1);
    chk(n <= 1046, 1'b1);
    repeat (3) @(posedge mclk_i);
    chk(irq_cnt, 1);
    // Standby and conversion swap after settling, with no new countdown, once the two-cycle resync ends
    host.wr_reg(ADDR_CFG0, {30'h0, PWR_STBY});
    repeat (4) @(posedge mclk_i);
    chk({conv, rdy}, 2'h1);
    host.wr_reg(ADDR_CFG0, {30'h0, PWR_CONV});
    repeat (5) @(posedge mclk_i);
    chk({conv, irq_cnt[1:0]}, 3'h6);
    host.wr_reg(ADDR_CFG0, 32'h00000000);
    repeat (2) @(posedge mclk_i);
    chk({conv, rdy}, 2'h0);
    host.rd_reg(ADDR_STAT, v);
    chk(v[8:0], SETTLE_FULL);
    // Clock source selection and divided clock output
    host.wr_reg(ADDR_CFG0, 32'h00000020);
    repeat (2) @(posedge mclk_i);
    chk({osc, ext, pin_oe}, 3'h4);
    chk(rst_cnt, 1);
    host.wr_reg(ADDR_CFG0, 32'h00000030);
    repeat (4) @(posedge mclk_i);
    tgl_cnt = 0;
    repeat (40) @(posedge mclk_i);
    chk({osc, ext, pin_oe}, 3'h5);
    chk(tgl_cnt >= 19 && tgl_cnt <= 21, 1'b1);
    host.wr_reg(ADDR_CFG0, 32'h00000033);
    repeat (400) @(posedge mclk_i);
    host.wr_reg(ADDR_CFG0, 32'h00000023);
    repeat (3) @(posedge mclk_i);
    host.rd_reg(ADDR_STAT, v);
    chk(v[8:0] >= 9'h0fd && rst_cnt == 3, 1'b1);
    host.wr_reg(ADDR_CFG0, 32'h00000003);
    repeat (2) @(posedge mclk_i);
    chk({osc, ext}, 2'h1);
    // Full shutdown command
    @(posedge mclk_i);
    fsd <= 1'b1;
    @(posedge mclk_i);
    fsd <= 1'b0;
    repeat (2) @(posedge mclk_i);
    ce_cnt = 0;
    repeat (20) @(posedge mclk_i);
    chk({gate, ce_cnt[0], conv}, 3'h0);
    host.rd_reg(ADDR_CFG0, v);
    chk(v, 32'h00000000);
    host.rd_reg(ADDR_STAT, v);
    chk(v[STAT_FSD_BIT], 1'b1);
    // Continuous scan with a short gap, then a long one
    host.wr_reg(ADDR_SCAN, 32'h00000403);
    host.wr_reg(ADDR_GAP, 32'h00000064);
    host.wr_reg(ADDR_CFG0, {30'h0, PWR_CONV});
    @(posedge mclk_i);
    chk(gate, 1'b1);
    scan_mode <= 1'b1;
    wait_conv(1'b1, 1200);
    chk(conv, 1'b1);
    scan_pulse();
    repeat (40) @(posedge mclk_i);
    host.rd_reg(ADDR_STAT, v);
    chk({v[9], v[8:0]}, 10'h000);
    wait_conv(1'b1, 600);
    chk(conv, 1'b1);
    host.wr_reg(ADDR_GAP, 32'h00000258);
    scan_pulse();
    repeat (20) @(posedge mclk_i);
    host.rd_reg(ADDR_STAT, v);
    chk({v[9], v[8:0]}, {1'b0, SETTLE_FULL});
    wait_conv(1'b1, 3000);
    n = cycles - t0;
    chk(n >= 2380 && n <= 2420, 1'b1);
    conclude();
  end
endmodule : adc_startup_timer_clock_select_tb_top

// ---- adcst_host.sv ----
`timescale 1ns/1ps
// ==========================================
// Host side of the register port
module adcst_host (
  // Clock
  input  wire logic        mclk_i,
  // Register port
  output logic      [7:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [31:0] rdata_i
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 32'h00000000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // Idle lines carry the inverse of the last value so stale data never passes
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd_reg
endmodule : adcst_host

// ---- adcst_pkg.sv ----
package adcst_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0]  ADDR_CFG0     = 8'h00;
  localparam logic [7:0]  ADDR_SCAN     = 8'h04;
  localparam logic [7:0]  ADDR_GAP      = 8'h08;
  localparam logic [7:0]  ADDR_STAT     = 8'h0c;
  // ==========================================
  // Field positions
  localparam int          CFG0_PWR_LSB  = 0;
  localparam int          CFG0_CLK_LSB  = 4;
  localparam int          SCAN_REP_LSB  = 0;
  localparam int          SCAN_STP_BIT  = 2;
  localparam int          SCAN_DIV_LSB  = 8;
  localparam int          STAT_CNT_LSB  = 0;
  localparam int          STAT_CONV_BIT = 9;
  localparam int          STAT_FSD_BIT  = 10;
  localparam int          STAT_SYNC_LSB = 11;
  localparam int          STAT_RDY_BIT  = 13;
  // ==========================================
  // Reset values
  localparam logic [7:0]  CFG0_RST      = 8'h00;
  localparam logic [1:0]  REP_RST       = 2'h0;
  localparam logic [7:0]  DIV_RST       = 8'h02;
  localparam logic [23:0] GAP_RST       = 24'h000000;
  // ==========================================
  // Codes
  localparam logic [1:0]  PWR_CONV      = 2'h3;
  localparam logic [1:0]  PWR_STBY      = 2'h2;
  localparam logic [1:0]  CLK_INT_OUT   = 2'h3;
  localparam logic [1:0]  REP_CONT      = 2'h3;
  // ==========================================
  // Timing counts, in master or modulator cycles
  localparam logic [8:0]  SETTLE_FULL   = 9'h100;
  localparam logic [1:0]  SYNC_WAIT     = 2'h2;
  localparam logic [3:0]  MOD_DIV       = 4'h4;
  localparam logic [7:0]  DIV_MIN       = 8'h02;

  typedef enum {SC_IDLE, SC_RUN, SC_GAP_SD, SC_GAP_SB} adcst_scan_t;
endpackage : adcst_pkg

// ---- adcst_seq.sv ----
`timescale 1ns/1ps
// Contract
// - Mode codes 11 convert, 10 standby, 0x shutdown
// - Entering shutdown is immediate, reloads 256
// - Leaving shutdown counts 256 down to 0
// - Bus-caused start waits two master cycles, unless the same write changes clock select
// - Scan-caused start counts down without waiting
// - At zero: standby ready, or conversion starts
// - Standby/convert switch immediate after zero only; the code still waits the two-cycle sync after each such bus write
// - Shutdown to conversion never below 256 periods
// - Same-value rewrite leaves countdown unchanged
// - Each 1x rewrite keeping clock select adds sync delay
// - Long continuous gap: shutdown, restart 256 early
// - Short gap: stay in standby
// - Start pulse on interrupt when enabled
// - Clock source select drives pin usage
// - Clock select change restarts everything
// - Full shutdown stops master clock distribution
// - Oscillator runs while select is 1x
// - Pin outputs divided clock at once
// - Full-shutdown command clears first config register
module adcst_seq
  import adcst_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Fast command and scan sequencer
  input  wire logic        full_shutdown_cmd_i,
  input  wire logic        scan_mode_i,
  input  wire logic        scan_cycle_done_i,
  // Converter control
  output logic             converting_o,
  output logic             adc_ready_o,
  output logic             conv_restart_o,
  output logic             modulator_ce_o,
  output logic             irq_o,
  // Clocking
  output logic             mclk_gate_en_o,
  output logic             osc_en_o,
  output logic             ext_clk_sel_o,
  output logic             clk_pin_o,
  output logic             clk_pin_oe_o
);

  // ==========================================
  // Registers
  logic [7:0]  first_config_reg;
  logic [1:0]  conversion_repeat_sel;
  logic        start_pulse_en;
  logic [7:0]  clk_divide_ratio;
  logic [23:0] scan_cycle_gap;
  logic        full_sd;

  logic [1:0]  adc_power_state_sel;
  logic [1:0]  clock_source_sel;
  logic        wr_cfg0;
  logic        clk_chg;
  logic        wr_mode_1x;

  assign adc_power_state_sel = first_config_reg[CFG0_PWR_LSB +: 2];
  assign clock_source_sel    = first_config_reg[CFG0_CLK_LSB +: 2];
  assign wr_cfg0    = wr_i && (addr_i == ADDR_CFG0);
  assign clk_chg    = wr_cfg0 && !full_shutdown_cmd_i
                      && (wdata_i[CFG0_CLK_LSB +: 2] != clock_source_sel);
  assign wr_mode_1x = wr_cfg0 && !full_shutdown_cmd_i && wdata_i[CFG0_PWR_LSB + 1];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      first_config_reg <= CFG0_RST;
    end else if (full_shutdown_cmd_i) begin
      first_config_reg <= CFG0_RST;
    end else if (wr_cfg0) begin
      first_config_reg <= wdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conversion_repeat_sel <= REP_RST;
      start_pulse_en        <= 1'b0;
      clk_divide_ratio      <= DIV_RST;
      scan_cycle_gap        <= GAP_RST;
    end else if (wr_i && addr_i == ADDR_SCAN) begin
      conversion_repeat_sel <= wdata_i[SCAN_REP_LSB +: 2];
      start_pulse_en        <= wdata_i[SCAN_STP_BIT];
      clk_divide_ratio      <= wdata_i[SCAN_DIV_LSB +: 8];
    end else if (wr_i && addr_i == ADDR_GAP) begin
      scan_cycle_gap        <= wdata_i[23:0];
    end
  end

  // Left by a later write to the first config register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      full_sd <= 1'b0;
    end else if (full_shutdown_cmd_i) begin
      full_sd <= 1'b1;
    end else if (wr_cfg0) begin
      full_sd <= 1'b0;
    end
  end

  // ==========================================
  // Modulator clock enable
  logic [3:0] mod_div_cnt;
  logic       mod_ce;

  always_ff @(posedge mclk_i) begin
    if (rst_i || clk_chg || full_sd) begin
      mod_div_cnt <= 4'h0;
    end else if (mod_div_cnt == MOD_DIV - 4'h1) begin
      mod_div_cnt <= 4'h0;
    end else begin
      mod_div_cnt <= mod_div_cnt + 4'h1;
    end
  end

  // No modulator tick in full shutdown: master clock is held off
  assign mod_ce         = !full_sd && (mod_div_cnt == MOD_DIV - 4'h1);
  assign modulator_ce_o = mod_ce;
  assign mclk_gate_en_o = !full_sd;

  // ==========================================
  // Scan gap handling
  adcst_scan_t scan_st;
  logic [23:0] gap_cnt;
  logic        scan_sd;
  logic        scan_hold;
  logic        gap_long;

  assign gap_long  = scan_cycle_gap > {15'h0, SETTLE_FULL};
  assign scan_sd   = (scan_st == SC_GAP_SD);
  assign scan_hold = (scan_st == SC_GAP_SB);

  always_ff @(posedge mclk_i) begin
    if (rst_i || !scan_mode_i || clk_chg) begin
      scan_st <= SC_IDLE;
      gap_cnt <= 24'h000000;
    end else begin
      case (scan_st)
        SC_IDLE: begin
          scan_st <= SC_RUN;
        end
        SC_RUN: begin
          if (scan_cycle_done_i && conversion_repeat_sel == REP_CONT) begin
            gap_cnt <= scan_cycle_gap;
            scan_st <= gap_long ? SC_GAP_SD : SC_GAP_SB;
          end
        end
        SC_GAP_SD: begin
          if (mod_ce) begin
            gap_cnt <= gap_cnt - 24'h000001;
          end
          // Wake early so settling ends with the gap
          if (gap_cnt <= {15'h0, SETTLE_FULL}) begin
            scan_st <= SC_GAP_SB;
          end
        end
        SC_GAP_SB: begin
          if (gap_cnt == 24'h000000) begin
            scan_st <= SC_RUN;
          end else if (mod_ce) begin
            gap_cnt <= gap_cnt - 24'h000001;
          end
        end
        default: begin
          scan_st <= SC_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Settle countdown
  logic [8:0] settle_cnt;
  logic [1:0] sync_cnt;
  logic       eff_sd;
  logic       conv;
  logic       conv_q;

  assign eff_sd = !adc_power_state_sel[1] || scan_sd || full_sd;

  // Resync after each bus write of a 1x mode that leaves the clock select unchanged
  always_ff @(posedge mclk_i) begin
    if (rst_i || clk_chg) begin
      sync_cnt <= 2'h0;
    end else if (wr_mode_1x) begin
      sync_cnt <= SYNC_WAIT;
    end else if (sync_cnt != 2'h0) begin
      sync_cnt <= sync_cnt - 2'h1;
    end
  end

  // Same-value writes touch nothing here, so the remaining time stays
  always_ff @(posedge mclk_i) begin
    if (rst_i || clk_chg) begin
      settle_cnt <= SETTLE_FULL;
    end else if (eff_sd) begin
      settle_cnt <= SETTLE_FULL;
    end else if (mod_ce && sync_cnt == 2'h0 && settle_cnt != 9'h000) begin
      settle_cnt <= settle_cnt - 9'h001;
    end
  end

  // Conversion only after full countdown and resync
  // A clock select change drops a running conversion in the same cycle
  assign conv = (adc_power_state_sel == PWR_CONV) && !eff_sd && !scan_hold && !clk_chg
                && settle_cnt == 9'h000 && sync_cnt == 2'h0;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      conv_q         <= 1'b0;
      irq_o          <= 1'b0;
      conv_restart_o <= 1'b0;
    end else begin
      conv_q         <= conv;
      irq_o          <= start_pulse_en && conv && !conv_q;
      conv_restart_o <= clk_chg;
    end
  end

  assign converting_o = conv_q;
  assign adc_ready_o  = !eff_sd && settle_cnt == 9'h000 && sync_cnt == 2'h0;

  // ==========================================
  // Clock source and divided output
  logic [7:0] out_cnt;
  logic [7:0] ratio;

  // Ratios below two cannot be made from flip-flops
  assign ratio = (clk_divide_ratio < DIV_MIN) ? DIV_MIN : clk_divide_ratio;

  always_ff @(posedge mclk_i) begin
    if (rst_i || clk_chg || full_sd) begin
      out_cnt   <= 8'h00;
      clk_pin_o <= 1'b0;
    end else begin
      out_cnt   <= (out_cnt >= ratio - 8'h01) ? 8'h00 : out_cnt + 8'h01;
      clk_pin_o <= out_cnt < {1'b0, ratio[7:1]};
    end
  end

  assign osc_en_o      = clock_source_sel[1];
  assign ext_clk_sel_o = !clock_source_sel[1];
  assign clk_pin_oe_o  = (clock_source_sel == CLK_INT_OUT);

  // ==========================================
  // Read port
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    case (addr_i)
      ADDR_CFG0: next_rdata[7:0] = first_config_reg;
      ADDR_SCAN: begin
        next_rdata[SCAN_REP_LSB +: 2] = conversion_repeat_sel;
        next_rdata[SCAN_STP_BIT]      = start_pulse_en;
        next_rdata[SCAN_DIV_LSB +: 8] = clk_divide_ratio;
      end
      ADDR_GAP:  next_rdata[23:0] = scan_cycle_gap;
      ADDR_STAT: begin
        next_rdata[STAT_CNT_LSB +: 9]  = settle_cnt;
        next_rdata[STAT_CONV_BIT]      = conv_q;
        next_rdata[STAT_FSD_BIT]       = full_sd;
        next_rdata[STAT_SYNC_LSB +: 2] = sync_cnt;
        next_rdata[STAT_RDY_BIT]       = adc_ready_o;
      end
      default:   next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // ==========================================
  // Checks
  property p_sd_reload;
    @(posedge mclk_i) disable iff (rst_i)
      eff_sd |=> settle_cnt == SETTLE_FULL;
  endproperty
  a_sd_reload: assert property (p_sd_reload) else $error("shutdown did not reload");

  property p_step;
    @(posedge mclk_i) disable iff (rst_i)
      (!eff_sd && !clk_chg && mod_ce && sync_cnt == 2'h0 && settle_cnt != 9'h000)
      |=> settle_cnt == $past(settle_cnt) - 9'h001;
  endproperty
  a_step: assert property (p_step) else $error("countdown did not step");

  property p_sync_hold;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_mode_1x && !clk_chg) |=> (sync_cnt != 2'h0 && !conv) [*2];
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("no resync wait");

  property p_conv_zero;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(conv_q) |-> $past(settle_cnt) == 9'h000 && $past(sync_cnt) == 2'h0;
  endproperty
  a_conv_zero: assert property (p_conv_zero) else $error("conversion before settle");

  property p_start_pulse;
    @(posedge mclk_i) disable iff (rst_i)
      (conv && !conv_q) |=> irq_o == $past(start_pulse_en) && converting_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse wrong");

  property p_pin_oe;
    @(posedge mclk_i) disable iff (rst_i)
      clk_pin_oe_o == (clock_source_sel == CLK_INT_OUT) && osc_en_o == clock_source_sel[1];
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("clock pin mode wrong");

  property p_clk_chg;
    @(posedge mclk_i) disable iff (rst_i)
      clk_chg |=> settle_cnt == SETTLE_FULL && conv_restart_o && !converting_o ##1 !conv_restart_o;
  endproperty
  a_clk_chg: assert property (p_clk_chg) else $error("clock change no restart");

  property p_fast_cmd;
    @(posedge mclk_i) disable iff (rst_i)
      full_shutdown_cmd_i |=> first_config_reg == CFG0_RST && !mclk_gate_en_o && !modulator_ce_o;
  endproperty
  a_fast_cmd: assert property (p_fast_cmd) else $error("fast shutdown failed");

  property p_short_gap;
    @(posedge mclk_i) disable iff (rst_i)
      scan_hold |-> !conv && !scan_sd;
  endproperty
  a_short_gap: assert property (p_short_gap) else $error("converted in gap");

  property p_resync;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_mode_1x && !clk_chg) |=> sync_cnt == SYNC_WAIT;
  endproperty
  a_resync: assert property (p_resync) else $error("rewrite gave no resync");

  property p_same_value;
    @(posedge mclk_i) disable iff (rst_i)
      (wr_cfg0 && !full_shutdown_cmd_i && !clk_chg && !eff_sd && !mod_ce
       && wdata_i[CFG0_PWR_LSB +: 2] == adc_power_state_sel)
      |=> settle_cnt == $past(settle_cnt);
  endproperty
  a_same_value: assert property (p_same_value) else $error("rewrite moved countdown");

  property p_conv_at_zero;
    @(posedge mclk_i) disable iff (rst_i)
      (adc_power_state_sel == PWR_CONV && adc_ready_o && !scan_hold && !clk_chg)
      |=> converting_o;
  endproperty
  a_conv_at_zero: assert property (p_conv_at_zero) else $error("no start at zero");

  property p_first_tick;
    @(posedge mclk_i) disable iff (rst_i)
      (!eff_sd && !clk_chg && mod_ce && sync_cnt == 2'h0 && settle_cnt == SETTLE_FULL)
      |=> settle_cnt == SETTLE_FULL - 9'h001;
  endproperty
  a_first_tick: assert property (p_first_tick) else $error("first step delayed");

  property p_reset_state;
    @(posedge mclk_i)
      $fell(rst_i) |-> settle_cnt == SETTLE_FULL && !converting_o && !adc_ready_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_gap_short;
    @(posedge mclk_i) disable iff (rst_i)
      (scan_mode_i && !clk_chg && scan_st == SC_RUN && scan_cycle_done_i
       && conversion_repeat_sel == REP_CONT && !gap_long) |=> scan_hold && !scan_sd;
  endproperty
  a_gap_short: assert property (p_gap_short) else $error("short gap not standby");

endmodule : adcst_seq
